// [mdfs_regs.vh]
// Purpose: Named constants for the motor driver fault supervisor.
// Assumes: 125 MHz system clock, 8 ns period.
// Notes:   Times are in nanoseconds; cycle counts derive from them.
`ifndef MDFS_REGS_VH
`define MDFS_REGS_VH

// ****************************************************************
// Clock and times
// ****************************************************************
`define MDFS_CLK_PERIOD_NS      8
`define MDFS_EN_LOW_MIN_NS      1000
`define MDFS_OCP_QUALIFY_NS     3000
`define MDFS_RETRY_NS           1600000
`define MDFS_SLEEP_ENTRY_NS     1000000
`define MDFS_WAKE_NS            1000000

// Least times round up, and none is below one cycle.
`define MDFS_EN_LOW_CYC   ((`MDFS_EN_LOW_MIN_NS + `MDFS_CLK_PERIOD_NS - 1) / `MDFS_CLK_PERIOD_NS)
`define MDFS_OCP_CYC      ((`MDFS_OCP_QUALIFY_NS + `MDFS_CLK_PERIOD_NS - 1) / `MDFS_CLK_PERIOD_NS)
`define MDFS_RETRY_CYC    (`MDFS_RETRY_NS / `MDFS_CLK_PERIOD_NS)
`define MDFS_SLEEP_CYC    (`MDFS_SLEEP_ENTRY_NS / `MDFS_CLK_PERIOD_NS)
`define MDFS_WAKE_CYC     (`MDFS_WAKE_NS / `MDFS_CLK_PERIOD_NS)

// ****************************************************************
// Widths and encodings
// ****************************************************************
`define MDFS_CNT_W        24
`define MDFS_POS_W        8
`define MDFS_POS_RESET    8'h00
`define MDFS_MODE_LATCH   1'b0
`define MDFS_MODE_RETRY   1'b1
`define MDFS_PWR_AWAKE    2'h0
`define MDFS_PWR_GOSLEEP  2'h1
`define MDFS_PWR_ASLEEP   2'h2
`define MDFS_PWR_WAKING   2'h3
`define MDFS_OC_RUN       2'h0
`define MDFS_OC_LATCHED   2'h1
`define MDFS_OC_RETRY     2'h2

`endif

// [mdfs_supervisor.v]
// Purpose: Fault supervision and mode control of a stepper driver.
// Assumes: Comparator inputs and host pins are synchronous to clk.
// Notes:   Long counts are parameters so a simulation may shorten them.
//
// Behaviour
// RULE1 - Pump undervoltage disables bridge, asserts fault
// RULE2 - Over-temperature disables bridge, auto resumes
// RULE3 - Sustained transistor current limit trips overcurrent
// RULE4 - Sense comparator above threshold trips overcurrent
// RULE5 - Latched or retry overcurrent response selectable
// RULE6 - Latched fault clears after enable low 1us
// RULE7 - Latched fault released when enable returns high
// RULE8 - Sleep toggle or power cycle clears latch
// RULE9 - Retry re-enables bridge, releases fault together
// RULE10 - Persistent overcurrent repeats disable-wait-retry cycle
// RULE11 - Host drives enable open-drain style in retry
// RULE12 - Sleep stops pump, regulator, indexer; bridge Hi-Z
// RULE13 - Sleep entered only after entry delay
// RULE14 - Wake on sleep high, outputs after wake delay
// RULE15 - Enable low disables bridge, pump keeps running
// RULE16 - Steps advance indexer while enable low
// RULE17 - Supply undervoltage keeps logic, indexer stepping
// RULE18 - Logic undervoltage resets logic and indexer position
// RULE19 - Fault output follows active sources until recovery
`timescale 1ns/1ps
`include "mdfs_regs.vh"

module mdfs_supervisor #(
    parameter [`MDFS_CNT_W-1:0] RETRY_CYC = `MDFS_RETRY_CYC,
    parameter [`MDFS_CNT_W-1:0] SLEEP_CYC = `MDFS_SLEEP_CYC,
    parameter [`MDFS_CNT_W-1:0] WAKE_CYC  = `MDFS_WAKE_CYC,
    parameter                   POS_W     = `MDFS_POS_W
) (
    input  wire             clk,
    input  wire             rst,
    input  wire             sleep_in_n,
    input  wire             enable_in,
    input  wire             step_in,
    input  wire             dir_in,
    input  wire             ocp_mode,
    input  wire             pump_undervoltage,
    input  wire             over_temperature,
    input  wire             fet_current_limit,
    input  wire             sense_overcurrent,
    input  wire             supply_undervoltage,
    input  wire             logic_undervoltage,
    output reg              fault_out_n,
    output reg              bridge_enable,
    output reg              bridge_hiz,
    output reg              pump_enable,
    output reg              aux_regulator_enable,
    output reg              indexer_run,
    output reg  [POS_W-1:0] indexer_pos,
    output reg  [POS_W-1:0] output_pos,
    output reg              overcurrent_fault
);

    localparam [`MDFS_CNT_W-1:0] OCP_CYC = `MDFS_OCP_CYC;
    localparam [`MDFS_CNT_W-1:0] ENL_CYC = `MDFS_EN_LOW_CYC;

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Saturating increment keeps the timers from wrapping.
    function [`MDFS_CNT_W-1:0] sat_inc;
        input [`MDFS_CNT_W-1:0] v;
        begin
            sat_inc = (&v) ? v : v + 1'b1;
        end
    endfunction

    reg                   lrst;
    reg [1:0]             pwr_state;
    reg [`MDFS_CNT_W-1:0] pwr_cnt;
    reg                   sleep_prev;
    reg                   step_prev;
    reg [1:0]             oc_state;
    reg [`MDFS_CNT_W-1:0] oc_cnt;
    reg                   oc_rearm;
    reg [`MDFS_CNT_W-1:0] lim_cnt;
    reg [`MDFS_CNT_W-1:0] enl_cnt;
    reg                   enl_done;
    wire                  awake;
    wire                  ocp_trip;
    wire                  sleep_toggle;
    wire                  hard_fault;

    // ****************************************************************
    // Internal reset
    // ****************************************************************

    // Logic undervoltage acts as a reset of all internal state.
    // RULE18 logic reset
    always @*
    begin
        lrst = rst | logic_undervoltage;
    end

    // ****************************************************************
    // Sleep and wake sequencing
    // ****************************************************************

    assign awake        = (pwr_state == `MDFS_PWR_AWAKE);
    assign sleep_toggle = sleep_prev & ~sleep_in_n;

    // Entry waits out the entry delay; wake waits out the wake delay.
    always @(posedge clk)
    begin
        if (lrst)
        begin
            pwr_state  <= `MDFS_PWR_AWAKE;
            pwr_cnt    <= {`MDFS_CNT_W{1'b0}};
            sleep_prev <= 1'b1;
        end
        else
        begin
            sleep_prev <= sleep_in_n;
            pwr_cnt    <= sat_inc(pwr_cnt);
            case (pwr_state)
                `MDFS_PWR_AWAKE:
                begin
                    pwr_cnt <= {`MDFS_CNT_W{1'b0}};
                    // RULE13 entry delay start
                    if (!sleep_in_n)
                        pwr_state <= `MDFS_PWR_GOSLEEP;
                end
                `MDFS_PWR_GOSLEEP:
                begin
                    if (sleep_in_n)
                    begin
                        pwr_state <= `MDFS_PWR_AWAKE;
                    end
                    // RULE13 entry delay elapsed
                    else if (pwr_cnt >= SLEEP_CYC - 1'b1)
                    begin
                        pwr_state <= `MDFS_PWR_ASLEEP;
                    end
                end
                `MDFS_PWR_ASLEEP:
                begin
                    pwr_cnt <= {`MDFS_CNT_W{1'b0}};
                    // RULE14 automatic wake
                    if (sleep_in_n)
                        pwr_state <= `MDFS_PWR_WAKING;
                end
                `MDFS_PWR_WAKING:
                begin
                    if (!sleep_in_n)
                    begin
                        pwr_state <= `MDFS_PWR_ASLEEP;
                    end
                    // RULE14 wake delay elapsed
                    else if (pwr_cnt >= WAKE_CYC - 1'b1)
                    begin
                        pwr_state <= `MDFS_PWR_AWAKE;
                    end
                end
                default:
                begin
                    pwr_state <= `MDFS_PWR_AWAKE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Overcurrent detection and recovery
    // ****************************************************************

    // RULE3 qualify current limit
    // RULE4 sense comparator trip
    assign ocp_trip = (lim_cnt >= OCP_CYC) | sense_overcurrent;

    // Count how long the transistor limit and the enable low have lasted.
    always @(posedge clk)
    begin
        if (lrst)
        begin
            lim_cnt  <= {`MDFS_CNT_W{1'b0}};
            enl_cnt  <= {`MDFS_CNT_W{1'b0}};
            enl_done <= 1'b0;
        end
        else
        begin
            lim_cnt <= fet_current_limit ? sat_inc(lim_cnt) : {`MDFS_CNT_W{1'b0}};
            enl_cnt <= enable_in ? {`MDFS_CNT_W{1'b0}} : sat_inc(enl_cnt);
            // RULE6 enable low 1us
            if (oc_state != `MDFS_OC_LATCHED)
                enl_done <= 1'b0;
            else if (!enable_in && enl_cnt >= ENL_CYC - 1'b1)
                enl_done <= 1'b1;
        end
    end

    // Recovery follows the selected response mode.
    // RULE5 mode selection
    always @(posedge clk)
    begin
        if (lrst)
        begin
            oc_state <= `MDFS_OC_RUN;
            oc_cnt   <= {`MDFS_CNT_W{1'b0}};
            oc_rearm <= 1'b0;
        end
        else
        begin
            oc_cnt   <= sat_inc(oc_cnt);
            oc_rearm <= 1'b0;
            case (oc_state)
                `MDFS_OC_RUN:
                begin
                    oc_cnt <= {`MDFS_CNT_W{1'b0}};
                    // RULE10 retrip while present
                    if (ocp_trip && awake)
                        oc_state <= (ocp_mode == `MDFS_MODE_RETRY) ?
                                    `MDFS_OC_RETRY : `MDFS_OC_LATCHED;
                end
                `MDFS_OC_LATCHED:
                begin
                    // RULE8 sleep clears latch
                    if (sleep_toggle)
                        oc_state <= `MDFS_OC_RUN;
                    // RULE7 release on enable high
                    else if (enl_done && enable_in)
                        oc_state <= `MDFS_OC_RUN;
                end
                `MDFS_OC_RETRY:
                begin
                    // RULE9 retry period elapsed
                    if (oc_cnt >= RETRY_CYC - 1'b1)
                    begin
                        oc_state <= `MDFS_OC_RUN;
                        oc_rearm <= 1'b1;
                    end
                end
                default:
                begin
                    oc_state <= `MDFS_OC_RUN;
                end
            endcase
        end
    end

    // ****************************************************************
    // Indexer
    // ****************************************************************

    // Steps advance the position whenever the indexer runs, even with
    // the bridge disabled; the bridge copy follows only when enabled.
    // RULE16 step while disabled
    // RULE17 step during supply lockout
    always @(posedge clk)
    begin
        if (lrst)
        begin
            step_prev   <= 1'b0;
            indexer_pos <= `MDFS_POS_RESET;
            output_pos  <= `MDFS_POS_RESET;
        end
        else
        begin
            step_prev <= step_in;
            if (indexer_run && step_in && !step_prev)
                indexer_pos <= dir_in ? indexer_pos + 1'b1 : indexer_pos - 1'b1;
            if (bridge_enable)
                output_pos <= indexer_pos;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    assign hard_fault = pump_undervoltage | over_temperature | supply_undervoltage;

    // Every output is registered; only the bridge enable is gated by power, fault and enable.
    always @(posedge clk)
    begin
        if (lrst)
        begin
            fault_out_n          <= 1'b1;
            bridge_enable        <= 1'b0;
            bridge_hiz           <= 1'b1;
            pump_enable          <= 1'b0;
            aux_regulator_enable <= 1'b0;
            indexer_run          <= 1'b0;
            overcurrent_fault    <= 1'b0;
        end
        else
        begin
            // RULE12 sleep shuts down
            indexer_run          <= (pwr_state != `MDFS_PWR_ASLEEP);
            aux_regulator_enable <= (pwr_state != `MDFS_PWR_ASLEEP);
            // RULE17 pump off in lockout
            pump_enable          <= (pwr_state != `MDFS_PWR_ASLEEP) & ~supply_undervoltage;
            // RULE15 enable gates bridge
            // RULE1 pump undervoltage off
            // RULE2 over-temperature off
            // RULE9 rearm with fault release
            // The cycle after a retry drives the bridge even if the trip persists.
            bridge_enable        <= awake & enable_in & ~hard_fault &
                                    (oc_state == `MDFS_OC_RUN) & (~ocp_trip | oc_rearm);
            bridge_hiz           <= (pwr_state == `MDFS_PWR_ASLEEP);
            overcurrent_fault    <= (oc_state != `MDFS_OC_RUN);
            // RULE19 fault output
            fault_out_n          <= ~(hard_fault | (oc_state != `MDFS_OC_RUN));
        end
    end

endmodule

// [mdfs_monitor.sv]
// Purpose: Port-level checks of the fault supervisor.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound into every supervisor instance.
`timescale 1ns/1ps
// ********************
// Checker
// ********************
module mdfs_monitor #(
    parameter POS_W = 8
) (
    input wire             clk,
    input wire             rst,
    input wire             sleep_in_n,
    input wire             enable_in,
    input wire             step_in,
    input wire             dir_in,
    input wire             ocp_mode,
    input wire             pump_undervoltage,
    input wire             over_temperature,
    input wire             fet_current_limit,
    input wire             sense_overcurrent,
    input wire             supply_undervoltage,
    input wire             logic_undervoltage,
    input wire             fault_out_n,
    input wire             bridge_enable,
    input wire             bridge_hiz,
    input wire             indexer_run,
    input wire [POS_W-1:0] indexer_pos,
    input wire             overcurrent_fault
);
reg [8:0] lim_cnt;
reg [7:0] low_run;
// Count consecutive current-limit samples and enable-low samples.
always @(posedge clk)
begin
    lim_cnt <= (rst || !fet_current_limit) ? 9'h000 : lim_cnt + {8'h00, lim_cnt != 9'h1FF};
    low_run <= (rst || enable_in) ? 8'h00 : low_run + {7'h00, low_run != 8'hFF};
end
default clocking @(posedge clk); endclocking
default disable iff (rst || logic_undervoltage);
// Each check ties an output to its cause at the inputs.
a_hard_fault:
assert property ((pump_undervoltage || over_temperature) && indexer_run
    |=> !fault_out_n && !bridge_enable) else $error("hard fault not reported");
a_fault_cause:
assert property (!fault_out_n |-> overcurrent_fault || $past(overcurrent_fault) ||
    $past(pump_undervoltage || over_temperature || supply_undervoltage)) else $error("stray fault");
a_sense_trip:
assert property ($rose(sense_overcurrent) && !overcurrent_fault && sleep_in_n && !bridge_hiz
    |-> ##2 overcurrent_fault && !fault_out_n) else $error("sense trip missed");
a_limit_trip:
assert property (lim_cnt == 9'h17C && !ocp_mode && sleep_in_n && !bridge_hiz
    |-> overcurrent_fault) else $error("limit trip missed");
a_latch_release:
assert property ($rose(enable_in) && !ocp_mode && overcurrent_fault && low_run > 8'h81 &&
    sleep_in_n && !(sense_overcurrent || fet_current_limit || pump_undervoltage ||
    over_temperature || supply_undervoltage) |-> ##2 fault_out_n) else $error("latch kept");
a_retry_together:
assert property (ocp_mode && $rose(fault_out_n) && $past(enable_in) && enable_in && sleep_in_n
    |-> bridge_enable) else $error("retry release split");
a_sleep_entry:
assert property ($fell(sleep_in_n) && indexer_run
    |-> indexer_run[*8] ##[1:6] bridge_hiz && !indexer_run) else $error("sleep entry timing");
a_step_advance:
assert property ($rose(step_in) && indexer_run |=> indexer_pos == ($past(dir_in) ?
    $past(indexer_pos) + 1'b1 : $past(indexer_pos) - 1'b1)) else $error("step not counted");
c_latch: cover property ($rose(fault_out_n) && !ocp_mode);
c_retry: cover property (ocp_mode && $rose(bridge_enable));
c_sleep: cover property ($rose(bridge_hiz));
endmodule

bind mdfs_supervisor mdfs_monitor #(.POS_W(POS_W)) u_mon (
    .clk                 (clk),
    .rst                 (rst),
    .sleep_in_n          (sleep_in_n),
    .enable_in           (enable_in),
    .step_in             (step_in),
    .dir_in              (dir_in),
    .ocp_mode            (ocp_mode),
    .pump_undervoltage   (pump_undervoltage),
    .over_temperature    (over_temperature),
    .fet_current_limit   (fet_current_limit),
    .sense_overcurrent   (sense_overcurrent),
    .supply_undervoltage (supply_undervoltage),
    .logic_undervoltage  (logic_undervoltage),
    .fault_out_n         (fault_out_n),
    .bridge_enable       (bridge_enable),
    .bridge_hiz          (bridge_hiz),
    .indexer_run         (indexer_run),
    .indexer_pos         (indexer_pos),
    .overcurrent_fault   (overcurrent_fault)
);

// [mdfs_host.sv]
// Purpose: Host controller model driving the control pins.
// Assumes: Pins change one nanosecond after the rising clock edge.
// Notes:   Enable is open-drain with a pull-up on the board.
`timescale 1ns/1ps
// ********************
// Host model
// ********************
module mdfs_host (
    input  wire  clk,
    output logic sleep_in_n,
    output wire  enable_in,
    output logic step_in,
    output logic dir_in
);
logic en_oe;
logic en_val;
// A released enable line floats up to its pull-up level.
assign enable_in = en_oe ? en_val : 1'b1;
initial
begin
    {sleep_in_n, step_in, dir_in, en_oe, en_val} = 5'h10;
end
task en_off;
begin
    @(posedge clk) #1 en_val = 1'b0;
    @(posedge clk) #1 en_oe = 1'b1;
end
endtask
task en_on;
    @(posedge clk) #1 en_oe = 1'b0;
endtask
// One step pulse, high for a single edge.
task step(input logic d);
begin
    @(posedge clk) #1 {step_in, dir_in} = {1'b1, d};
    @(posedge clk) #1 step_in = 1'b0;
end
endtask
task sleep_set(input logic v);
    @(posedge clk) #1 sleep_in_n = v;
endtask
endmodule

// [mdfs_tb.sv]
// Purpose: Self-checking bench of the fault supervisor.
// Assumes: Short retry, sleep and wake counts.
// Notes:   Inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
// ********************
// Bench
// ********************
module tb;
logic clk, rst, ocp_mode, pump_undervoltage, over_temperature, fet_current_limit;
logic sense_overcurrent, supply_undervoltage, logic_undervoltage;
wire sleep_in_n, enable_in, step_in, dir_in, fault_out_n, bridge_enable, bridge_hiz;
wire pump_enable, aux_regulator_enable, indexer_run, overcurrent_fault;
wire [7:0] indexer_pos, output_pos;
int err_count = 0;
int n_tests = 0;
mdfs_supervisor #(.RETRY_CYC(24'h000014), .SLEEP_CYC(24'h00000A), .WAKE_CYC(24'h00000A)) uut (
    .clk                  (clk),
    .rst                  (rst),
    .sleep_in_n           (sleep_in_n),
    .enable_in            (enable_in),
    .step_in              (step_in),
    .dir_in               (dir_in),
    .ocp_mode             (ocp_mode),
    .pump_undervoltage    (pump_undervoltage),
    .over_temperature     (over_temperature),
    .fet_current_limit    (fet_current_limit),
    .sense_overcurrent    (sense_overcurrent),
    .supply_undervoltage  (supply_undervoltage),
    .logic_undervoltage   (logic_undervoltage),
    .fault_out_n          (fault_out_n),
    .bridge_enable        (bridge_enable),
    .bridge_hiz           (bridge_hiz),
    .pump_enable          (pump_enable),
    .aux_regulator_enable (aux_regulator_enable),
    .indexer_run          (indexer_run),
    .indexer_pos          (indexer_pos),
    .output_pos           (output_pos),
    .overcurrent_fault    (overcurrent_fault)
);
mdfs_host host (
    .clk        (clk),
    .sleep_in_n (sleep_in_n),
    .enable_in  (enable_in),
    .step_in    (step_in),
    .dir_in     (dir_in)
);
// Clock of 8 ns.
initial
begin
    clk = 1'b0;
    forever #4 clk = ~clk;
end
task tk(input int n);
    repeat (n) @(posedge clk);
    #1;
endtask
task chk1(input string nm, input logic e, input logic g);
begin
    n_tests++;
    if (g !== e)
    begin
        err_count++;
        $display("CHECK FAILED %s exp %b got %b", nm, e, g);
    end
end
endtask
task chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
begin
    n_tests++;
    if (g !== e)
    begin
        err_count++;
        $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
end
endtask
task test_step;
begin
    host.en_off();
    repeat (3) host.step(1'b1);
    tk(2);
    chk8("idx", 8'h03, indexer_pos);
    chk8("out", 8'h00, output_pos);
    chk1("pump", 1'b1, pump_enable);
    host.en_on();
    tk(4);
    chk8("out", 8'h03, output_pos);
    supply_undervoltage = 1'b1;
    host.step(1'b0);
    tk(2);
    chk8("idx", 8'h02, indexer_pos);
    chk1("pump", 1'b0, pump_enable);
    supply_undervoltage = 1'b0;
    logic_undervoltage = 1'b1;
    tk(2);
    logic_undervoltage = 1'b0;
    tk(3);
    chk8("idx", 8'h00, indexer_pos);
    $display("test_step done");
end
endtask
task test_hard;
begin
    for (int i = 0; i < 2; i++)
    begin
        pump_undervoltage = (i == 0);
        over_temperature = (i != 0);
        tk(3);
        chk1("fault", 1'b0, fault_out_n);
        chk1("bridge", 1'b0, bridge_enable);
        pump_undervoltage = 1'b0;
        over_temperature = 1'b0;
        tk(3);
        chk1("fault", 1'b1, fault_out_n);
        chk1("bridge", 1'b1, bridge_enable);
    end
    $display("test_hard done");
end
endtask
task test_latch;
begin
    sense_overcurrent = 1'b1;
    tk(1);
    sense_overcurrent = 0;
    tk(4);
    chk1("fault", 1'b0, fault_out_n);
    chk1("ocf", 1'b1, overcurrent_fault);
    host.en_off();
    tk(50);
    host.en_on();
    tk(4);
    chk1("fault", 1'b0, fault_out_n);
    host.en_off();
    tk(130);
    host.en_on();
    tk(4);
    chk1("fault", 1'b1, fault_out_n);
    $display("test_latch done");
end
endtask
task test_limit;
begin
    fet_current_limit = 1'b1;
    tk(370);
    fet_current_limit = 1'b0;
    tk(4);
    chk1("fault", 1'b1, fault_out_n);
    fet_current_limit = 1'b1;
    tk(380);
    fet_current_limit = 1'b0;
    tk(4);
    chk1("fault", 1'b0, fault_out_n);
    host.sleep_set(1'b0);
    tk(5);
    chk1("run", 1'b1, indexer_run);
    tk(10);
    chk1("hiz", 1'b1, bridge_hiz);
    chk1("aux", 1'b0, aux_regulator_enable);
    chk1("pump", 1'b0, pump_enable);
    host.sleep_set(1'b1);
    tk(5);
    chk1("bridge", 1'b0, bridge_enable);
    tk(10);
    chk1("fault", 1'b1, fault_out_n);
    chk1("bridge", 1'b1, bridge_enable);
    $display("test_limit done");
end
endtask
task test_retry;
    int hi;
    int be;
begin
    hi = 0;
    be = 0;
    ocp_mode = 1'b1;
    sense_overcurrent = 1'b1;
    tk(1);
    sense_overcurrent = 0;
    tk(4);
    chk1("fault", 1'b0, fault_out_n);
    tk(30);
    chk1("bridge", 1'b1, bridge_enable);
    sense_overcurrent = 1'b1;
    repeat (60)
    begin
        tk(1);
        hi += (fault_out_n === 1'b1);
        be += (bridge_enable === 1'b1);
    end
    chk1("retries", 1'b1, hi > 2 && hi < 8);
    chk1("rearm", 1'b1, be > 1 && be == hi - 1);
    sense_overcurrent = 0;
    tk(30);
    chk1("fault", 1'b1, fault_out_n);
    $display("test_retry done");
end
endtask
task report_and_stop;
begin
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
        $display("Run complete: PASS");
    else
        $display("Run complete: FAIL");
    $finish;
end
endtask
// Watchdog well beyond the expected run length.
initial
begin
    repeat (4000) @(posedge clk);
    err_count++;
    report_and_stop();
end
// Main sequence after a 20-cycle reset.
initial
begin
    ocp_mode = 1'b0;
    pump_undervoltage = 1'b0;
    over_temperature = 1'b0;
    fet_current_limit = 1'b0;
    sense_overcurrent = 1'b0;
    supply_undervoltage = 1'b0;
    logic_undervoltage = 1'b0;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    tk(2);
    test_step();
    test_hard();
    test_latch();
    test_limit();
    test_retry();
    report_and_stop();
end
endmodule
